// file: src/shf_system_handler.sv
// System handler priority, control/state and configurable fault status over APB
// How it works
// - Priority two: supervisor call priority bits 31:24
// - Priority three: tick timer priority bits 31:24
// - Priority three: pendable service priority bits 23:16
// - Enables: usage 18, bus 17, memory 16
// - Pending bits 15..12, readable and directly writable
// - Active bits 11,10,8,7,3,1,0 read active
// - Writes to active bits change active state
// - Disabled configurable fault escalates to hard fault
// - Fetch violation sets flag, no address captured
// - Execute-never access always gives fetch violation
// - Load/store violation sets flag, captures address
// - Unstacking violation sets flag, no address
// - Stacking violation sets flag, no address
// - Usage flags at bits 19,18,17,16
// - Priority bytes keep only upper nibble
// - Address valid only while address register valid
// - Lazy float save violation has own flag
// - Low byte is memory fault status byte
//
// Added by the designer: register access over APB and the register offsets.
`include "shf_defs.svh"

module shf_system_handler (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Fault causes from the core
  input  wire shf_pkg::shf_mem_fault_s    memFault,
  input  wire logic                       execNeverHit,
  input  wire logic                       busFaultIn,
  input  wire shf_pkg::shf_usage_fault_s  usageFault,
  // Exception state from the core
  input  wire logic                       svcPendSet,
  input  wire logic [6:0]                 activeSet,
  input  wire logic [6:0]                 activeClr,
  // Towards the core
  output shf_pkg::shf_exc_e               excRaise_ff,
  output logic      [3:0]                 svcPriority,
  output logic      [3:0]                 pendPriority,
  output logic      [3:0]                 tickPriority,
  output logic      [2:0]                 faultEnable
);

  logic [31:0] prio2_ff, nxt_prio2;
  logic [31:0] prio3_ff, nxt_prio3;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] fault_ff, nxt_fault;
  logic [31:0] faultAddr_ff, nxt_faultAddr;
  shf_pkg::shf_exc_e nxt_exc;
  shf_pkg::shf_apb_e apbState_ff, nxt_apbState;

  logic        wrEn;
  logic [31:0] byteMask;
  logic        memEvent;
  logic        usageEvent;
  logic        fetchHit;
  logic        known;

  // Byte enables widened to a bit mask; priorities are byte accessible
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // Masked byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] lanes, input logic [31:0] impl);
    merge = ((old & ~lanes) | (wd & lanes)) & impl;
  endfunction : merge

  // Zero wait state: access phase completes in its first cycle
  assign pready  = psel & penable;
  assign wrEn    = psel & penable & pwrite;
  assign byteMask = strb_mask(pstrb);

  always_comb
  begin
    unique case (paddr)
      `SHF_ADDR_PRIO_TWO, `SHF_ADDR_PRIO_THREE, `SHF_ADDR_CTRL_STATE,
      `SHF_ADDR_FAULT_STATUS, `SHF_ADDR_FAULT_ADDR: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~known;

  always_comb
  begin
    nxt_apbState = (psel & ~penable) ? shf_pkg::SHF_ACCESS : shf_pkg::SHF_IDLE;
  end

  // Execute-never regions fault even with no protection unit present
  assign fetchHit   = memFault.fetchViol | execNeverHit;
  assign memEvent   = fetchHit | memFault.ldstViol | memFault.unstack | memFault.stack
                    | memFault.lazySave;
  assign usageEvent = |usageFault;

  // Priority registers
  always_comb
  begin
    nxt_prio2 = prio2_ff;
    nxt_prio3 = prio3_ff;
    if (wrEn && paddr == `SHF_ADDR_PRIO_TWO)
      nxt_prio2 = merge(prio2_ff, pwdata, byteMask, 32'hf0000000);
    if (wrEn && paddr == `SHF_ADDR_PRIO_THREE)
      nxt_prio3 = merge(prio3_ff, pwdata, byteMask, 32'hf0f00000);
  end

  // Control and state: software write first, hardware set wins over it
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wrEn && paddr == `SHF_ADDR_CTRL_STATE)
      nxt_ctrl = merge(ctrl_ff, pwdata, byteMask, `SHF_CTRL_MASK);
    nxt_ctrl[`SHF_BIT_MON_ACT]  = (nxt_ctrl[`SHF_BIT_MON_ACT]  & ~activeClr[6]) | activeSet[6];
    nxt_ctrl[`SHF_BIT_TICK_ACT] = (nxt_ctrl[`SHF_BIT_TICK_ACT] & ~activeClr[5]) | activeSet[5];
    nxt_ctrl[`SHF_BIT_PEND_ACT] = (nxt_ctrl[`SHF_BIT_PEND_ACT] & ~activeClr[4]) | activeSet[4];
    nxt_ctrl[`SHF_BIT_SVC_ACT]  = (nxt_ctrl[`SHF_BIT_SVC_ACT]  & ~activeClr[3]) | activeSet[3];
    nxt_ctrl[`SHF_BIT_USG_ACT]  = (nxt_ctrl[`SHF_BIT_USG_ACT]  & ~activeClr[2]) | activeSet[2];
    nxt_ctrl[`SHF_BIT_BUS_ACT]  = (nxt_ctrl[`SHF_BIT_BUS_ACT]  & ~activeClr[1]) | activeSet[1];
    nxt_ctrl[`SHF_BIT_MEM_ACT]  = (nxt_ctrl[`SHF_BIT_MEM_ACT]  & ~activeClr[0]) | activeSet[0];
    if (svcPendSet)
      nxt_ctrl[`SHF_BIT_SVC_PEND] = 1'b1;
    // Enabled faults pend their own handler; disabled ones escalate instead
    if (memEvent && ctrl_ff[`SHF_BIT_MEM_EN])
      nxt_ctrl[`SHF_BIT_MEM_PEND] = 1'b1;
    if (busFaultIn && ctrl_ff[`SHF_BIT_BUS_EN])
      nxt_ctrl[`SHF_BIT_BUS_PEND] = 1'b1;
    if (usageEvent && ctrl_ff[`SHF_BIT_USG_EN])
      nxt_ctrl[`SHF_BIT_USG_PEND] = 1'b1;
  end

  // Exception request; hard fault outranks the specific ones in the same cycle
  always_comb
  begin
    nxt_exc = shf_pkg::SHF_EXC_NONE;
    if ((memEvent && !ctrl_ff[`SHF_BIT_MEM_EN]) || (busFaultIn && !ctrl_ff[`SHF_BIT_BUS_EN])
        || (usageEvent && !ctrl_ff[`SHF_BIT_USG_EN]))
      nxt_exc = shf_pkg::SHF_EXC_HARD;
    else if (memEvent)
      nxt_exc = shf_pkg::SHF_EXC_MEM;
    else if (busFaultIn)
      nxt_exc = shf_pkg::SHF_EXC_BUS;
    else if (usageEvent)
      nxt_exc = shf_pkg::SHF_EXC_USAGE;
  end

  // Fault status is write-one-to-clear; a new cause in the same cycle wins
  always_comb
  begin
    nxt_fault     = fault_ff;
    nxt_faultAddr = faultAddr_ff;
    if (wrEn && paddr == `SHF_ADDR_FAULT_STATUS)
      nxt_fault = fault_ff & ~(pwdata & byteMask);
    if (fetchHit)
      nxt_fault[`SHF_BIT_FETCH_VIOL] = 1'b1;
    if (memFault.unstack)
      nxt_fault[`SHF_BIT_UNSTK] = 1'b1;
    if (memFault.stack)
      nxt_fault[`SHF_BIT_STK] = 1'b1;
    if (memFault.lazySave)
      nxt_fault[`SHF_BIT_LAZY] = 1'b1;
    if (memFault.ldstViol)
    begin
      nxt_fault[`SHF_BIT_LDST_VIOL]  = 1'b1;
      nxt_fault[`SHF_BIT_ADDR_VALID] = 1'b1;
      nxt_faultAddr = memFault.addr;
    end
    if (usageFault.coproc)
      nxt_fault[`SHF_BIT_COPROCESSOR_ACCESS_FAULT] = 1'b1;
    if (usageFault.invReturn)
      nxt_fault[`SHF_BIT_INVALID_RETURN_LOAD_FAULT] = 1'b1;
    if (usageFault.invalid_state_fault)
      nxt_fault[`SHF_BIT_INVALID_STATE_FAULT] = 1'b1;
    if (usageFault.undefined_instruction_fault)
      nxt_fault[`SHF_BIT_UNDEF] = 1'b1;
    nxt_fault = nxt_fault & `SHF_FAULT_MASK;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prio2_ff     <= `SHF_RESET_WORD;
      prio3_ff     <= `SHF_RESET_WORD;
      ctrl_ff      <= `SHF_RESET_WORD;
      fault_ff     <= `SHF_RESET_WORD;
      faultAddr_ff <= `SHF_RESET_WORD;
      excRaise_ff  <= shf_pkg::SHF_EXC_NONE;
      apbState_ff  <= shf_pkg::SHF_IDLE;
    end
    else
    begin
      prio2_ff     <= nxt_prio2;
      prio3_ff     <= nxt_prio3;
      ctrl_ff      <= nxt_ctrl;
      fault_ff     <= nxt_fault;
      faultAddr_ff <= nxt_faultAddr;
      excRaise_ff  <= nxt_exc;
      apbState_ff  <= nxt_apbState;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (paddr)
      `SHF_ADDR_PRIO_TWO:     prdata = prio2_ff;
      `SHF_ADDR_PRIO_THREE:   prdata = prio3_ff;
      `SHF_ADDR_CTRL_STATE:   prdata = ctrl_ff;
      `SHF_ADDR_FAULT_STATUS: prdata = fault_ff;
      `SHF_ADDR_FAULT_ADDR:   prdata = faultAddr_ff;
      default:                prdata = 32'h00000000;
    endcase
  end

  assign svcPriority  = prio2_ff[`SHF_SVC_PRI_HI -: 4];
  assign tickPriority = prio3_ff[`SHF_TICK_PRI_HI -: 4];
  assign pendPriority = prio3_ff[`SHF_PEND_PRI_HI -: 4];
  assign faultEnable  = ctrl_ff[`SHF_BIT_USG_EN:`SHF_BIT_MEM_EN];

endmodule : shf_system_handler

// file: inc/shf_defs.svh
// Offsets, field positions and reset values of the system handler fault block
`ifndef SHF_DEFS_SVH
`define SHF_DEFS_SVH

`define SHF_ADDR_PRIO_TWO     12'h000
`define SHF_ADDR_PRIO_THREE   12'h004
`define SHF_ADDR_CTRL_STATE   12'h008
`define SHF_ADDR_FAULT_STATUS 12'h00c
`define SHF_ADDR_FAULT_ADDR   12'h010

`define SHF_SVC_PRI_HI        31
`define SHF_TICK_PRI_HI       31
`define SHF_PEND_PRI_HI       23
`define SHF_PRI_IMPL_MSB      7
`define SHF_PRI_IMPL_LSB      4

`define SHF_BIT_USG_EN        18
`define SHF_BIT_BUS_EN        17
`define SHF_BIT_MEM_EN        16
`define SHF_BIT_SVC_PEND      15
`define SHF_BIT_BUS_PEND      14
`define SHF_BIT_MEM_PEND      13
`define SHF_BIT_USG_PEND      12
`define SHF_BIT_TICK_ACT      11
`define SHF_BIT_PEND_ACT      10
`define SHF_BIT_MON_ACT       8
`define SHF_BIT_SVC_ACT       7
`define SHF_BIT_USG_ACT       3
`define SHF_BIT_BUS_ACT       1
`define SHF_BIT_MEM_ACT       0
`define SHF_CTRL_MASK         32'h0007fd8b

`define SHF_BIT_FETCH_VIOL    0
`define SHF_BIT_LDST_VIOL     1
`define SHF_BIT_UNSTK         3
`define SHF_BIT_STK           4
`define SHF_BIT_LAZY          5
`define SHF_BIT_ADDR_VALID    7
`define SHF_BIT_COPROCESSOR_ACCESS_FAULT          19
`define SHF_BIT_INVALID_RETURN_LOAD_FAULT         18
`define SHF_BIT_INVALID_STATE_FAULT      17
`define SHF_BIT_UNDEF         16
`define SHF_FAULT_MASK        32'h000f00bb

`define SHF_RESET_WORD        32'h00000000

`endif

// file: inc/shf_pkg.sv
// Types for the system handler fault block
package shf_pkg;

  // Memory fault causes reported by the core in one cycle
  typedef struct packed {
    logic        fetchViol;
    logic        ldstViol;
    logic        unstack;
    logic        stack;
    logic        lazySave;
    logic [31:0] addr;
  } shf_mem_fault_s;

  // Usage fault causes reported by the core
  typedef struct packed {
    logic coproc;
    logic invReturn;
    logic invalid_state_fault;
    logic undefined_instruction_fault;
  } shf_usage_fault_s;

  // Exception raised towards the core
  typedef enum logic [2:0] {
    SHF_EXC_NONE  = 3'b000,
    SHF_EXC_MEM   = 3'b001,
    SHF_EXC_BUS   = 3'b010,
    SHF_EXC_USAGE = 3'b011,
    SHF_EXC_HARD  = 3'b100
  } shf_exc_e;

  typedef enum logic [0:0] {
    SHF_IDLE   = 1'b0,
    SHF_ACCESS = 1'b1
  } shf_apb_e;

endpackage : shf_pkg

// file: bench/shf_system_handler_monitor.sv
// Checker bound to the system handler fault block
`include "shf_defs.svh"
module shf_system_handler_monitor (
  // APB side
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic [31:0]               prdata,
  // Core side
  input wire shf_pkg::shf_mem_fault_s   memFault,
  input wire logic                      execNeverHit,
  input wire logic                      busFaultIn,
  input wire shf_pkg::shf_usage_fault_s usageFault,
  input wire shf_pkg::shf_exc_e         excRaise_ff,
  input wire logic [3:0]                svcPriority,
  input wire logic [3:0]                pendPriority,
  input wire logic [3:0]                tickPriority,
  input wire logic [2:0]                faultEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic wrOk;
  logic rdSel;
  assign wrOk = psel && penable && pwrite;
  assign rdSel = psel && !pwrite;
  property p_svc_pri;
    wrOk && paddr == 12'h000 && pstrb[3] |=> svcPriority == $past(pwdata[31:28]);
  endproperty
  a_svc_pri: assert property (p_svc_pri) else $error("svc priority not stored");
  property p_tick_pri;
    wrOk && paddr == 12'h004 && pstrb[3] |=> tickPriority == $past(pwdata[31:28]);
  endproperty
  a_tick_pri: assert property (p_tick_pri) else $error("tick priority not stored");
  property p_pend_pri;
    wrOk && paddr == 12'h004 && pstrb[2] |=> pendPriority == $past(pwdata[23:20]);
  endproperty
  a_pend_pri: assert property (p_pend_pri) else $error("pend priority not stored");
  property p_enable;
    wrOk && paddr == 12'h008 && pstrb[2] |=> faultEnable == $past(pwdata[18:16]);
  endproperty
  a_enable: assert property (p_enable) else $error("enables not stored");
  property p_pri_low;
    rdSel && paddr == 12'h004 |-> (prdata & 32'h0f0fffff) == 32'h0;
  endproperty
  a_pri_low: assert property (p_pri_low) else $error("priority low bits not zero");
  property p_fault_res;
    rdSel && paddr == 12'h00c |-> (prdata & ~32'h000f00bb) == 32'h0;
  endproperty
  a_fault_res: assert property (p_fault_res) else $error("fault reserved bits set");
  property p_hard;
    (memFault.ldstViol || memFault.fetchViol) && !faultEnable[0]
      |=> excRaise_ff == shf_pkg::SHF_EXC_HARD;
  endproperty
  a_hard: assert property (p_hard) else $error("disabled fault not escalated");
  property p_mem;
    (memFault.fetchViol || execNeverHit) && faultEnable[0] && !busFaultIn
      && usageFault == 4'h0 |=> excRaise_ff == shf_pkg::SHF_EXC_MEM;
  endproperty
  a_mem: assert property (p_mem) else $error("fetch violation not raised");
endmodule : shf_system_handler_monitor

bind shf_system_handler shf_system_handler_monitor shf_system_handler_monitor_i (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .memFault(memFault),
  .execNeverHit(execNeverHit), .busFaultIn(busFaultIn), .usageFault(usageFault),
  .excRaise_ff(excRaise_ff), .svcPriority(svcPriority), .pendPriority(pendPriority),
  .tickPriority(tickPriority), .faultEnable(faultEnable));

// file: bench/shf_core_model.sv
// Behavioural core that reports fault causes and exception state changes
module shf_core_model (
  // Command from the bench
  input  wire logic [0:0]          sys_clk,
  input  wire logic                go,
  input  wire logic [3:0]          kind,
  input  wire logic [31:0]         addr,
  // Causes towards the block
  output shf_pkg::shf_mem_fault_s  memFault,
  output logic                     execNeverHit,
  output logic                     busFaultIn,
  output shf_pkg::shf_usage_fault_s usageFault,
  output logic                     svcPendSet,
  output logic [6:0]               activeSet,
  output logic [6:0]               activeClr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hit;
  assign hit = go ? (16'h0001 << kind) : 16'h0000;
  always_ff @(posedge sys_clk)
  begin
    {memFault.lazySave, memFault.stack, memFault.unstack} <= hit[4:2];
    {memFault.ldstViol, memFault.fetchViol} <= hit[1:0];
    // Address only means something with a load/store violation, so scramble it otherwise
    memFault.addr <= hit[1] ? addr : ~addr;
    {busFaultIn, usageFault, execNeverHit} <= hit[10:5];
    svcPendSet <= hit[11];
    activeSet <= {1'b0, hit[12], 5'h00};
    activeClr <= {1'b0, hit[13], 5'h00};
  end
endmodule : shf_core_model

// file: bench/tb.sv
// Self-checking bench for the system handler fault block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      sys_clk, rst, psel, penable, pwrite, pready, pslverr, go, errv;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rdv, lfsr, fAddr, expAddr, saved;
  logic [3:0]                pstrb, kind, svcPri, pendPri, tickPri;
  logic [6:0]                actSet, actClr;
  logic [2:0]                excSeen;
  logic                      svcSet, nxHit, busIn;
  logic [2:0]                faultEn;
  shf_pkg::shf_mem_fault_s   memFault;
  shf_pkg::shf_usage_fault_s usageFault;
  shf_pkg::shf_exc_e         excRaise;
  int                        err_count = 0, total_checks = 0, cyc = 0;

  shf_system_handler shf_system_handler_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memFault(memFault),
    .execNeverHit(nxHit), .busFaultIn(busIn), .usageFault(usageFault), .svcPendSet(svcSet),
    .activeSet(actSet), .activeClr(actClr), .excRaise_ff(excRaise), .svcPriority(svcPri),
    .pendPriority(pendPri), .tickPriority(tickPri), .faultEnable(faultEn));
  shf_core_model shf_core_model_i (.sys_clk(sys_clk), .go(go), .kind(kind), .addr(fAddr),
    .memFault(memFault), .execNeverHit(nxHit), .busFaultIn(busIn), .usageFault(usageFault),
    .svcPendSet(svcSet), .activeSet(actSet), .activeClr(actClr));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  function automatic logic [31:0] expFault(input int k);
    case (k)
      0, 5: return 32'h1;
      1: return 32'h82;
      2: return 32'h8;
      3: return 32'h10;
      4: return 32'h20;
      6, 7, 8, 9: return 32'h1 << (k + 10);
      default: return 32'h0;
    endcase
  endfunction : expFault

  // Exception expected from one fired cause while all three faults are enabled
  function automatic logic [31:0] expExc(input int k);
    if (k <= 5)
      return 32'h1;
    else if (k <= 9)
      return 32'h3;
    else if (k == 10)
      return 32'h2;
    return 32'h0;
  endfunction : expExc

  // Setup then access; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fire(input logic [3:0] k, input logic [31:0] a);
    @(posedge sys_clk);
    go <= 1'b1;
    kind <= k;
    fAddr <= a;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    // The exception request stands for the one cycle after the cause is taken
    @(posedge sys_clk);
    excSeen = excRaise;
    @(posedge sys_clk);
  endtask : fire

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    {psel, penable, pwrite, go} = 4'h0;
    {paddr, pwdata, pstrb, kind, fAddr} = '0;
    lfsr = 32'd74693;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0, 4'hf);
      check(rdv, 32'h0);
    end
    apb(1'b1, 12'h014, 32'hffffffff, 4'hf);
    apb(1'b0, 12'h014, 32'h0, 4'hf);
    check(rdv | {31'h0, ~errv}, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nextRand(lfsr);
      apb(1'b1, 12'h000, lfsr, 4'hf);
      apb(1'b0, 12'h000, 32'h0, 4'hf);
      check(rdv, lfsr & 32'hf0000000);
      apb(1'b1, 12'h004, lfsr, 4'hf);
      apb(1'b1, 12'h004, ~lfsr, 4'h4);
      apb(1'b0, 12'h004, 32'h0, 4'hf);
      check(rdv, (lfsr & 32'hf0000000) | (~lfsr & 32'h00f00000));
      apb(1'b1, 12'h008, lfsr, 4'hf);
      apb(1'b0, 12'h008, 32'h0, 4'hf);
      check(rdv, lfsr & 32'h0007fd8b);
    end
    apb(1'b1, 12'h008, 32'h00070000, 4'hf);
    for (int k = 0; k < 12; k++)
    begin
      lfsr = nextRand(lfsr);
      if (k == 1)
        expAddr = lfsr;
      fire(4'(k), lfsr);
      check({29'h0, excSeen}, expExc(k));
      apb(1'b0, 12'h00c, 32'h0, 4'hf);
      check(rdv, expFault(k));
      apb(1'b1, 12'h00c, 32'hffffffff, 4'hf);
    end
    apb(1'b0, 12'h010, 32'h0, 4'hf);
    check(rdv, expAddr);
    fire(4'd12, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'hf);
    check(rdv, 32'h0007f800);
    saved = rdv;
    apb(1'b1, 12'h008, saved | 32'h80, 4'hf);
    apb(1'b0, 12'h008, 32'h0, 4'hf);
    check(rdv, 32'h0007f880);
    apb(1'b1, 12'h008, saved, 4'hf);
    fire(4'd13, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'hf);
    check(rdv, 32'h0007f000);
    apb(1'b1, 12'h008, 32'h0, 4'hf);
    fire(4'd1, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 4'hf);
    check(rdv, 32'h0);
    check({29'h0, excSeen}, 32'h4);
    // Reset again with flags and the pendable service priority still set; priority two and the fault address already hold zero
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0, 4'hf);
      check(rdv, 32'h0);
    end
    summarize();
  end
endmodule : tb
